// *** rtl/frex_strobe_sequencer.sv ***
// frame exposure timing: precharge, exposure, shutter, flash, readout
//
// Behaviour
// - exposure counts 24 bits, 128 clocks each
// - flash lasts 20-bit count of clocks
// - shutter delay 13 bits, 128 clocks each
// - precharge lasts 16-bit count of clocks
// - readout delay 16 bits, 128 clocks each
// - flash start delayed by 13-bit strobe delay
// - repeat request retriggers at SOF or EOF
// - request bit set by software, self-clears
// - flash output picks rolling or frame strobe
// - flash polarity bit inverts flash output
// - shutter polarity bit inverts shutter output
// - capture source: register request or trigger pad
// - request waits for SOF unless bypassed
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module frex_strobe_sequencer
  import frex_seq_pkg::*;
(
  input  wire logic        i_sys_clk,          // 25 MHz system clock
  input  wire logic        i_rst,              // async, active high
  input  wire logic        i_clk_en,           // freezes all state when low
  // avalon-mm slave, byte addressed
  input  wire logic [15:0] i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // sensor timing, same clock domain
  input  wire logic        i_sof,              // start of frame pulse
  input  wire logic        i_eof,              // end of frame pulse
  input  wire logic        i_rolling_strobe,   // rolling-mode strobe
  // external trigger pad, asynchronous
  input  wire logic        i_trigger_pad,
  // timing outputs
  output logic             o_flash,            // flash, polarity applied
  output logic             o_shutter,          // shutter, polarity applied
  output logic             o_precharge,        // precharge phase active
  output logic             o_exposing,         // exposure phase active
  output logic             o_readout_start,    // one-cycle pulse
  output logic             o_busy              // capture in progress
);

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [REG_COUNT-1:0][7:0] regs;       // register storage
    logic                      ack;        // bus answer cycle
    logic [7:0]                rdata;      // read data
    logic                      pad_s1;     // pad synchroniser first
    logic                      pad_s2;     // pad synchroniser second
    logic                      pad_prev;   // for rising edge
    logic                      repeat_arm; // a register capture has run
    logic                      reg_cap;    // current capture from register
    phase_t                    phase;      // capture phase
    flash_t                    fl;         // flash phase
    logic                      flash;      // output registers
    logic                      shutter;
    logic                      pchg;
    logic                      expo;
    logic                      rd_start;
  } state_t;

  state_t st_q;
  state_t st_d;

  // timer handshakes
  logic                   ph_start;   // start phase timer
  logic [TIMER_WIDTH-1:0] ph_len;     // phase length
  logic                   ph_done;    // last cycle of phase
  logic                   fl_start;   // start flash timer
  logic [TIMER_WIDTH-1:0] fl_len;     // flash delay or width
  logic                   fl_done;    // last cycle of flash step

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // map a word index onto a storage slot
  function automatic logic [4:0] slot_of(input logic [13:0] idx);
    case (idx)
      IDX_EXP_HIGH:    slot_of = {1'b1, SLOT_EXP_H};
      IDX_EXP_MID:     slot_of = {1'b1, SLOT_EXP_M};
      IDX_EXP_LOW:     slot_of = {1'b1, SLOT_EXP_L};
      IDX_FLEN_HIGH:   slot_of = {1'b1, SLOT_FLEN_H};
      IDX_FLEN_MID:    slot_of = {1'b1, SLOT_FLEN_M};
      IDX_FLEN_LOW:    slot_of = {1'b1, SLOT_FLEN_L};
      IDX_SHUT_HIGH:   slot_of = {1'b1, SLOT_SHUT_H};
      IDX_SHUT_LOW:    slot_of = {1'b1, SLOT_SHUT_L};
      IDX_PCHG_HIGH:   slot_of = {1'b1, SLOT_PCHG_H};
      IDX_PCHG_LOW:    slot_of = {1'b1, SLOT_PCHG_L};
      IDX_RDWT_HIGH:   slot_of = {1'b1, SLOT_RDWT_H};
      IDX_RDWT_LOW:    slot_of = {1'b1, SLOT_RDWT_L};
      IDX_FDLY_HIGH:   slot_of = {1'b1, SLOT_FDLY_H};
      IDX_FDLY_LOW:    slot_of = {1'b1, SLOT_FDLY_L};
      IDX_REPEAT_SEL:  slot_of = {1'b1, SLOT_REPEAT};
      IDX_CAPTURE_CTL: slot_of = {1'b1, SLOT_CTRL};
      default:         slot_of = 5'h00;
    endcase
  endfunction : slot_of

  // scale a coarse count to clocks, 128 per step
  function automatic logic [TIMER_WIDTH-1:0] coarse(input logic [23:0] n);
    coarse = TIMER_WIDTH'({n, {STEP_SHIFT{1'b0}}});
  endfunction : coarse

  ////////////////////////////////////////////////////////////////////////
  // decoded settings

  logic [23:0] exp_cnt;
  logic [19:0] flen_cnt;
  logic [12:0] shut_cnt;
  logic [15:0] pchg_cnt;
  logic [15:0] rdwt_cnt;
  logic [12:0] fdly_cnt;
  logic [7:0]  ctl;

  assign exp_cnt  = {st_q.regs[SLOT_EXP_H], st_q.regs[SLOT_EXP_M],
                     st_q.regs[SLOT_EXP_L]};
  assign flen_cnt = {st_q.regs[SLOT_FLEN_H][3:0],
                     st_q.regs[SLOT_FLEN_M], st_q.regs[SLOT_FLEN_L]};
  assign shut_cnt = {st_q.regs[SLOT_SHUT_H][4:0],
                     st_q.regs[SLOT_SHUT_L]};
  assign pchg_cnt = {st_q.regs[SLOT_PCHG_H], st_q.regs[SLOT_PCHG_L]};
  assign rdwt_cnt = {st_q.regs[SLOT_RDWT_H], st_q.regs[SLOT_RDWT_L]};
  assign fdly_cnt = {st_q.regs[SLOT_FDLY_H][4:0],
                     st_q.regs[SLOT_FDLY_L]};
  assign ctl      = st_q.regs[SLOT_CTRL];

  ////////////////////////////////////////////////////////////////////////
  // timers: one for the capture phases, one for the flash

  frex_phase_timer #(.WIDTH(TIMER_WIDTH)) u_phase_timer (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_clk_en  (i_clk_en),
    .i_start   (ph_start),
    .i_len     (ph_len),
    .o_busy    (),
    .o_done    (ph_done)
  );

  frex_phase_timer #(.WIDTH(TIMER_WIDTH)) u_flash_timer (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_clk_en  (i_clk_en),
    .i_start   (fl_start),
    .i_len     (fl_len),
    .o_busy    (),
    .o_done    (fl_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    logic [4:0] sl;        // decoded slot, bit 4 = mapped
    logic       wr_take;   // write takes effect this edge
    logic       pad_rise;  // synchronised pad edge
    logic       boundary;  // frame point a latched request waits for
    logic       reg_go;    // register request taken
    logic       start_cap; // capture begins
    sl        = slot_of(i_avs_address[15:2]);
    wr_take   = 1'b0;
    pad_rise  = 1'b0;
    boundary  = 1'b0;
    reg_go    = 1'b0;
    start_cap = 1'b0;
    st_d      = st_q;
    ph_start  = 1'b0;
    ph_len    = '0;
    fl_start  = 1'b0;
    fl_len    = '0;

    // bus: one wait cycle, then answer on the ack cycle
    st_d.ack = (i_avs_read || i_avs_write) && !st_q.ack;
    if ((i_avs_read || i_avs_write) && !st_q.ack)
    begin
      if (sl[4])
        st_d.rdata = st_q.regs[sl[3:0]] & REG_MASK[sl[3:0]];
      else if (i_avs_address[15:2] == IDX_STATUS)
        st_d.rdata = {3'h0, (st_q.fl == FL_ON), st_q.repeat_arm,
                      st_q.phase};
      else
        st_d.rdata = 8'h00;
    end
    wr_take = i_avs_write && st_q.ack && i_avs_byteenable[0] && sl[4];
    if (wr_take)
      st_d.regs[sl[3:0]] = i_avs_writedata[7:0] & REG_MASK[sl[3:0]];

    // pad synchroniser; only the second stage is looked at
    st_d.pad_s1   = i_trigger_pad;
    st_d.pad_s2   = st_q.pad_s1;
    st_d.pad_prev = st_q.pad_s2;
    pad_rise      = st_q.pad_s2 && !st_q.pad_prev;

    // pick the frame point a latched request waits for
    if (st_q.repeat_arm && st_q.regs[SLOT_REPEAT][REPEAT_EOF_BIT])
      boundary = i_eof;
    else
      boundary = i_sof;

    // capture start, only while idle
    if (st_q.phase == PH_IDLE)
    begin
      if (ctl[CTL_PAD_BIT])
        start_cap = pad_rise;
      else if (ctl[CTL_REQ_BIT])
      begin
        reg_go    = ctl[CTL_NOLATCH_BIT] || boundary;
        start_cap = reg_go;
      end
    end
    // request self-clears when taken; a new write of 1 in the same
    // cycle wins and stays pending for the next capture
    if (reg_go && !(wr_take && sl[3:0] == SLOT_CTRL
                    && i_avs_writedata[CTL_REQ_BIT]))
      st_d.regs[SLOT_CTRL][CTL_REQ_BIT] = 1'b0;

    // capture phases
    st_d.rd_start = 1'b0;
    case (st_q.phase)
      PH_IDLE:
      begin
        if (start_cap)
        begin
          st_d.reg_cap = reg_go;
          if (ctl[CTL_NOPCHG_BIT])
          begin
            st_d.phase = PH_EXPOSE;
            ph_len     = coarse(exp_cnt);
            st_d.fl    = FL_DELAY;
            fl_start   = 1'b1;
            fl_len     = TIMER_WIDTH'(fdly_cnt);
          end
          else
          begin
            st_d.phase = PH_PRECHARGE;
            ph_len     = TIMER_WIDTH'(pchg_cnt);
          end
          ph_start = 1'b1;
        end
      end
      PH_PRECHARGE:
      begin
        if (ph_done)
        begin
          st_d.phase = PH_EXPOSE;
          ph_start   = 1'b1;
          ph_len     = coarse(exp_cnt);
          st_d.fl    = FL_DELAY;
          fl_start   = 1'b1;
          fl_len     = TIMER_WIDTH'(fdly_cnt);
        end
      end
      PH_EXPOSE:
      begin
        if (ph_done)
        begin
          st_d.phase = PH_SHUTTER;
          ph_start   = 1'b1;
          ph_len     = coarse({11'h000, shut_cnt});
        end
      end
      PH_SHUTTER:
      begin
        if (ph_done)
        begin
          st_d.phase = PH_READOUT;
          ph_start   = 1'b1;
          ph_len     = coarse({8'h00, rdwt_cnt});
        end
      end
      PH_READOUT:
      begin
        if (ph_done)
        begin
          st_d.phase    = PH_IDLE;
          st_d.rd_start = 1'b1;
          // later register requests retrigger at the chosen point
          if (st_q.reg_cap)
            st_d.repeat_arm = 1'b1;
        end
      end
      default:
        st_d.phase = PH_IDLE;
    endcase

    // switching to pad mode ends a run of repeated requests
    if (ctl[CTL_PAD_BIT])
      st_d.repeat_arm = 1'b0;

    // flash: delay after exposure start, then the programmed width
    case (st_q.fl)
      FL_IDLE: ;
      FL_DELAY:
      begin
        if (fl_done)
        begin
          st_d.fl  = FL_ON;
          fl_start = 1'b1;
          fl_len   = TIMER_WIDTH'(flen_cnt);
        end
      end
      FL_ON:
      begin
        if (fl_done)
          st_d.fl = FL_IDLE;
      end
      default:
        st_d.fl = FL_IDLE;
    endcase

    // registered outputs from the next state
    st_d.pchg    = (st_d.phase == PH_PRECHARGE);
    st_d.expo    = (st_d.phase == PH_EXPOSE);
    // shutter held open from exposure until its close delay ends
    st_d.shutter = ((st_d.phase == PH_EXPOSE) ||
                    (st_d.phase == PH_SHUTTER))
                   ^ st_d.regs[SLOT_CTRL][CTL_SPOL_BIT];
    st_d.flash   = (st_d.regs[SLOT_CTRL][CTL_OUT_SEL_BIT]
                    ? (st_d.fl == FL_ON) : i_rolling_strobe)
                   ^ st_d.regs[SLOT_CTRL][CTL_FPOL_BIT];
  end

  ////////////////////////////////////////////////////////////////////////
  // state register, frozen while the clock enable is low

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_q         <= '0;
      st_q.regs    <= REG_RESET;
      st_q.phase   <= PH_IDLE;
      st_q.fl      <= FL_IDLE;
      // reset control has both polarity bits clear except shutter
      st_q.shutter <= REG_RESET[SLOT_CTRL][CTL_SPOL_BIT];
      st_q.flash   <= REG_RESET[SLOT_CTRL][CTL_FPOL_BIT];
    end
    else if (i_clk_en)
      st_q <= st_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  // waitrequest holds the master for exactly one cycle while the clock enable is high
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !st_q.ack;
  assign o_avs_readdata    = {24'h000000, st_q.rdata};
  assign o_flash           = st_q.flash;
  assign o_shutter         = st_q.shutter;
  assign o_precharge       = st_q.pchg;
  assign o_exposing        = st_q.expo;
  assign o_readout_start   = st_q.rd_start;
  assign o_busy            = (st_q.phase != PH_IDLE);

endmodule : frex_strobe_sequencer
`default_nettype wire

// *** rtl/frex_seq_pkg.sv ***
// constants shared by the frame exposure strobe sequencer files
package frex_seq_pkg;

  // register word indices; byte address on the bus is four times these
  localparam logic [13:0] IDX_EXP_HIGH    = 14'h3f85;
  localparam logic [13:0] IDX_EXP_MID     = 14'h3f86;
  localparam logic [13:0] IDX_EXP_LOW     = 14'h3f87;
  localparam logic [13:0] IDX_FLEN_HIGH   = 14'h3f89;
  localparam logic [13:0] IDX_FLEN_MID    = 14'h3f8a;
  localparam logic [13:0] IDX_FLEN_LOW    = 14'h3f8b;
  localparam logic [13:0] IDX_SHUT_HIGH   = 14'h3f8c;
  localparam logic [13:0] IDX_SHUT_LOW    = 14'h3f8d;
  localparam logic [13:0] IDX_PCHG_HIGH   = 14'h3f8e;
  localparam logic [13:0] IDX_PCHG_LOW    = 14'h3f8f;
  localparam logic [13:0] IDX_RDWT_HIGH   = 14'h3f90;
  localparam logic [13:0] IDX_RDWT_LOW    = 14'h3f91;
  localparam logic [13:0] IDX_FDLY_HIGH   = 14'h3f92;
  localparam logic [13:0] IDX_FDLY_LOW    = 14'h3f93;
  localparam logic [13:0] IDX_REPEAT_SEL  = 14'h3f9e;
  localparam logic [13:0] IDX_CAPTURE_CTL = 14'h3f9f;
  localparam logic [13:0] IDX_STATUS      = 14'h3fa0;

  // storage slots of the writable registers
  localparam int unsigned REG_COUNT   = 16;
  localparam logic [3:0]  SLOT_EXP_H  = 4'h0;
  localparam logic [3:0]  SLOT_EXP_M  = 4'h1;
  localparam logic [3:0]  SLOT_EXP_L  = 4'h2;
  localparam logic [3:0]  SLOT_FLEN_H = 4'h3;
  localparam logic [3:0]  SLOT_FLEN_M = 4'h4;
  localparam logic [3:0]  SLOT_FLEN_L = 4'h5;
  localparam logic [3:0]  SLOT_SHUT_H = 4'h6;
  localparam logic [3:0]  SLOT_SHUT_L = 4'h7;
  localparam logic [3:0]  SLOT_PCHG_H = 4'h8;
  localparam logic [3:0]  SLOT_PCHG_L = 4'h9;
  localparam logic [3:0]  SLOT_RDWT_H = 4'ha;
  localparam logic [3:0]  SLOT_RDWT_L = 4'hb;
  localparam logic [3:0]  SLOT_FDLY_H = 4'hc;
  localparam logic [3:0]  SLOT_FDLY_L = 4'hd;
  localparam logic [3:0]  SLOT_REPEAT = 4'he;
  localparam logic [3:0]  SLOT_CTRL   = 4'hf;

  // reset values, slot 15 first
  localparam logic [REG_COUNT-1:0][7:0] REG_RESET = {
    8'h04, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h40, 8'h1f,
    8'h44, 8'h00, 8'h00, 8'h06, 8'h00, 8'h05, 8'h00, 8'h00};

  // implemented bits per slot, unused bits read zero
  localparam logic [REG_COUNT-1:0][7:0] REG_MASK = {
    8'hbf, 8'h01, 8'hff, 8'h1f, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'h1f, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'hff};

  // capture control fields
  localparam int unsigned CTL_REQ_BIT     = 7;
  localparam int unsigned CTL_OUT_SEL_BIT = 5;
  localparam int unsigned CTL_NOPCHG_BIT  = 4;
  localparam int unsigned CTL_FPOL_BIT    = 3;
  localparam int unsigned CTL_SPOL_BIT    = 2;
  localparam int unsigned CTL_PAD_BIT     = 1;
  localparam int unsigned CTL_NOLATCH_BIT = 0;
  localparam int unsigned REPEAT_EOF_BIT  = 0;

  // one coarse count step is 2**STEP_SHIFT = 128 system clocks
  localparam int unsigned STEP_SHIFT  = 7;
  localparam int unsigned TIMER_WIDTH = 31;

  // capture phases and flash phases
  typedef enum logic [2:0] {
    PH_IDLE, PH_PRECHARGE, PH_EXPOSE, PH_SHUTTER, PH_READOUT
  } phase_t;
  typedef enum logic [1:0] {FL_IDLE, FL_DELAY, FL_ON} flash_t;

endpackage : frex_seq_pkg

// *** rtl/frex_phase_timer.sv ***
// down counter that times one phase in whole system clock cycles
`timescale 1ns/100ps
`default_nettype none
module frex_phase_timer
  import frex_seq_pkg::*;
#(
  parameter int unsigned WIDTH = TIMER_WIDTH
)(
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  input  wire logic             i_clk_en,
  input  wire logic             i_start,
  input  wire logic [WIDTH-1:0] i_len,
  output logic                  o_busy,
  output logic                  o_done
);

  // a one-bit counter cannot tell the last cycle from a running one
  if (WIDTH < 2)
  begin : g_width_check
    $error("timer width too small");
  end

  typedef struct packed {
    logic             busy; // phase running
    logic [WIDTH-1:0] cnt;  // cycles left, 1 means last
  } tmr_t;

  tmr_t st_q;
  tmr_t st_d;

  ////////////////////////////////////////////////////////////////////////
  // a length of zero still costs one cycle, so phases never overlap
  always_comb
  begin
    st_d = st_q;
    if (i_start)
    begin
      st_d.busy = 1'b1;
      st_d.cnt  = (i_len == '0) ? WIDTH'(1) : i_len;
    end
    else if (st_q.busy)
    begin
      if (st_q.cnt == WIDTH'(1))
        st_d.busy = 1'b0;
      else
        st_d.cnt = st_q.cnt - WIDTH'(1);
    end
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      st_q <= '0;
    else if (i_clk_en)
      st_q <= st_d;
  end

  assign o_busy = st_q.busy;
  // done marks the last cycle of the phase
  assign o_done = st_q.busy && (st_q.cnt == WIDTH'(1)) && i_clk_en;

endmodule : frex_phase_timer
`default_nettype wire

// *** testbench/frex_seq_monitor.sv ***
// port assertions for the frame exposure sequencer
`timescale 1ns/100ps
`default_nettype none
module frex_seq_monitor (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic o_busy,
  input wire logic o_precharge,
  input wire logic o_exposing,
  input wire logic o_shutter,
  input wire logic o_readout_start
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  //////////////////////////////////////////////////////////////////////////
  // a capture opens in precharge, or in exposure when precharge is skipped
  property p_open;
    $rose(o_busy) |-> o_precharge || o_exposing;
  endproperty
  a_open: assert property (p_open) else $error("capture opened idle");
  // precharge hands over straight to exposure
  property p_order;
    $fell(o_precharge) && o_busy |-> o_exposing;
  endproperty
  a_order: assert property (p_order) else $error("no exposure");
  property p_excl;
    !(o_precharge && o_exposing);
  endproperty
  a_excl: assert property (p_excl) else $error("phases overlap");
  // the capture ends exactly with the readout start pulse
  property p_end;
    $fell(o_busy) |-> o_readout_start;
  endproperty
  a_end: assert property (p_end) else $error("end without pulse");
  // pulse is one cycle; a frozen clock enable may stretch it
  property p_pulse;
    o_readout_start && i_clk_en |-> !o_busy ##1 !o_readout_start;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse too long");
  // shutter stays put inside the exposure when nothing is written
  property p_shut;
    o_exposing && $past(o_exposing) && $past(o_exposing, 2)
      && !$past(i_avs_write) |-> $stable(o_shutter);
  endproperty
  a_shut: assert property (p_shut) else $error("shutter moved");
  // the bus answers after exactly one wait cycle while the clock enable is high
  property p_wait;
    (i_avs_read || i_avs_write) && o_avs_waitrequest && i_clk_en
      |=> !o_avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");
  // a low clock enable freezes busy and the exposure output
  property p_freeze;
    !i_clk_en |=> $stable(o_busy) && $stable(o_exposing);
  endproperty
  a_freeze: assert property (p_freeze) else $error("not frozen");
  c_cap: cover property ($rose(o_busy));
  c_skip: cover property ($rose(o_busy) && o_exposing);
  c_end: cover property (o_readout_start);
endmodule : frex_seq_monitor
`default_nettype wire

// *** testbench/frex_far_side.sv ***
// frame timing, rolling strobe and trigger pad around the sequencer
`timescale 1ns/100ps
`default_nettype none
module frex_far_side (
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  input  wire logic i_pad_go,
  output logic      o_sof,
  output logic      o_eof,
  output logic      o_rolling_strobe,
  output logic      o_trigger_pad
);
  logic [9:0] cnt_q; // position in a 1000-cycle frame
  logic [3:0] pad_q; // cycles of pad pulse still to hold
  //////////////////////////////////////////////////////////////////////////
  // free running frames; the pad is held long enough for a synchroniser
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_q <= '0;
      pad_q <= '0;
    end
    else
    begin
      cnt_q <= (cnt_q == 10'd999) ? '0 : cnt_q + 10'd1;
      pad_q <= i_pad_go ? 4'h8 : pad_q - {3'h0, pad_q != 4'h0};
    end
  end
  assign o_sof = (cnt_q == 10'd1);
  assign o_eof = (cnt_q == 10'd700);
  assign o_rolling_strobe = cnt_q[3];
  assign o_trigger_pad = (pad_q != 4'h0);
endmodule : frex_far_side
`default_nettype wire

// *** testbench/test_frame_exposure_strobe_sequencer.sv ***
// self-checking bench of the frame exposure strobe sequencer
`timescale 1ns/100ps
`default_nettype none
module test_frame_exposure_strobe_sequencer;
  import frex_seq_pkg::*;
  logic clk = 0, rst = 1, clk_en = 1, rd = 0, wr = 0, pad_go = 0;
  logic [15:0] addr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] be = 4'hf;
  logic wreq, sof, eof, roll, pad, flash, shut, pchg, expo, rs, busy;
  logic fpol = 0, spol = 0, seen, at_sof, at_eof, p_sof, p_eof, p_busy;
  logic [7:0] q;
  int fails = 0, check_count = 0, cyc = 0, t_go;
  int n_pc, n_ex, n_sh, n_fl, n_post, n_dly;
  // reset value, write value, read-back value per register
  logic [37:0] rows [17] = '{
    {14'h3f85, 24'h00a5a5}, {14'h3f86, 24'h001111},
    {14'h3f87, 24'h055a5a}, {14'h3f89, 24'h00ff0f},
    {14'h3f8a, 24'h068181}, {14'h3f8b, 24'h004444},
    {14'h3f8c, 24'h00ff1f}, {14'h3f8d, 24'h443c3c},
    {14'h3f8e, 24'h1fe1e1}, {14'h3f8f, 24'h400202},
    {14'h3f90, 24'h002222}, {14'h3f91, 24'h017e7e},
    {14'h3f92, 24'h00ff1f}, {14'h3f93, 24'h003333},
    {14'h3f9e, 24'h01ff01}, {14'h3f9f, 24'h047f3f},
    {14'h3f88, 24'h00ff00}};
  // short counts: exposure 1, precharge 2, shutter 1, flash 3 after 2
  logic [21:0] setup [7] = '{{14'h3f87, 8'h01}, {14'h3f8e, 8'h00},
    {14'h3f8f, 8'h02}, {14'h3f8d, 8'h01}, {14'h3f8a, 8'h00},
    {14'h3f8b, 8'h03}, {14'h3f93, 8'h02}};
  frex_strobe_sequencer i_dut (.i_sys_clk(clk), .i_rst(rst),
    .i_clk_en(clk_en), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_sof(sof),
    .i_eof(eof), .i_rolling_strobe(roll), .i_trigger_pad(pad),
    .o_flash(flash), .o_shutter(shut), .o_precharge(pchg),
    .o_exposing(expo), .o_readout_start(rs), .o_busy(busy));
  frex_far_side i_far (.i_sys_clk(clk), .i_rst(rst), .i_pad_go(pad_go),
    .o_sof(sof), .o_eof(eof), .o_rolling_strobe(roll),
    .o_trigger_pad(pad));
  //////////////////////////////////////////////////////////////////////////
  initial forever #20 clk = ~clk;
  // phase lengths measured in enabled cycles, in active polarity
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fails++;
      conclude();
    end
    if (clk_en)
    begin
      n_pc += pchg;
      n_ex += expo;
      n_sh += shut ^ spol;
      n_fl += flash ^ fpol;
      n_post += busy & !pchg & !expo;
      if (flash ^ fpol) seen = 1;
      if (busy && !seen) n_dly += expo;
      if (busy && !p_busy) {at_sof, at_eof} = {p_sof, p_eof};
      {p_sof, p_eof, p_busy} = {sof, eof, busy};
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic [13:0] idx, input logic w,
                     input logic [7:0] d);
    @(posedge clk);
    addr <= {idx, 2'b00};
    rd <= !w;
    wr <= w;
    wdata <= {24'h0, d};
    // no assumed latency: only the cycle ceiling ends this wait
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata[7:0];
    rd <= 0;
    wr <= 0;
  endtask : bus
  task automatic do_reset;
    rst <= 1;
    repeat (8) @(posedge clk);
    rst <= 0;
    @(posedge clk);
  endtask : do_reset
  // one capture with a short clock enable freeze inside it
  task automatic run(input logic [7:0] c, input logic use_pad);
    bus(IDX_CAPTURE_CTL, 1, c);
    pad_go <= use_pad;
    @(posedge clk);
    pad_go <= 0;
    // count only once the new polarities already stand on the pins
    {n_pc, n_ex, n_sh, n_fl, n_post, n_dly, seen} = '0;
    t_go = 0;
    do
    begin
      @(posedge clk);
      t_go++;
    end
    while (busy !== 1'b1);
    clk_en <= 0;
    repeat (5) @(posedge clk);
    clk_en <= 1;
    do @(posedge clk); while (busy !== 1'b0);
    check("rs", rs, 1);
  endtask : run
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic r;
    do_reset();
    check("idle", {flash, shut, busy}, 3'b010);
    foreach (rows[i])
    begin
      bus(rows[i][37:24], 0, 0);
      check("reset", q, rows[i][23:16]);
      bus(rows[i][37:24], 1, rows[i][15:8]);
      bus(rows[i][37:24], 0, 0);
      check("rdback", q, rows[i][7:0]);
    end
    be <= 4'h0;
    bus(IDX_EXP_LOW, 1, 8'hff);
    be <= 4'hf;
    bus(IDX_EXP_LOW, 0, 0);
    check("be0", q, 8'h5a);
    do_reset();
    foreach (setup[i]) bus(setup[i][21:8], 1, setup[i][7:0]);
    run(8'ha1, 0);
    check("pchg", n_pc, 2);
    check("expo", n_ex, 128);
    check("shut", n_sh, 256);
    check("post", n_post, 256);
    check("flen", n_fl, 3);
    check("fdly", n_dly, 2);
    bus(IDX_CAPTURE_CTL, 0, 0);
    check("selfclr", q, 8'h21);
    bus(IDX_STATUS, 0, 0);
    check("status", q, 8'h08);
    {fpol, spol} = 2'b11;
    run(8'had, 0);
    check("flash", flash, 1);
    check("flen_l", n_fl, 3);
    check("shut_l", n_sh, 256);
    {fpol, spol} = 2'b00;
    bus(IDX_EXP_LOW, 1, 8'h02);
    run(8'hb1, 0);
    check("nopchg", n_pc, 0);
    check("expo2", n_ex, 256);
    run(8'h23, 1);
    check("pad", t_go < 8, 1);
    run(8'ha0, 0);
    check("sof", at_sof, 1);
    run(8'ha0, 0);
    check("eof", at_eof, 1);
    bus(IDX_REPEAT_SEL, 1, 8'h00);
    run(8'ha0, 0);
    check("sof2", at_sof, 1);
    bus(IDX_CAPTURE_CTL, 1, 8'h01);
    @(posedge clk);
    r = roll;
    repeat (20)
    begin
      @(posedge clk);
      check("roll", flash, r);
      r = roll;
    end
    conclude();
  end
endmodule : test_frame_exposure_strobe_sequencer
bind frex_strobe_sequencer frex_seq_monitor i_mon (.i_sys_clk(i_sys_clk),
  .i_rst(i_rst), .i_clk_en(i_clk_en), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
  .o_busy(o_busy), .o_precharge(o_precharge), .o_exposing(o_exposing),
  .o_shutter(o_shutter), .o_readout_start(o_readout_start));
`default_nettype wire
